// *** shared/wdit_params.svh ***
/*
 * offsets, field positions, reset values and counts of the watchdog interval timer.
 * assumes: included by bare name; definitions only.
 */
`ifndef WDIT_PARAMS_SVH
`define WDIT_PARAMS_SVH

// register byte addresses on the avalon slave
`define WDIT_CTRL_ADDR     32'h5200_0000
`define WDIT_RELOAD_ADDR   32'h5200_0004
`define WDIT_COUNT_ADDR    32'h5200_0008

// control field positions
`define WDIT_PRESC_HI      15
`define WDIT_PRESC_LO      8
`define WDIT_EN_BIT        5
`define WDIT_DIV_HI        4
`define WDIT_DIV_LO        3
`define WDIT_IRQ_BIT       2
`define WDIT_RST_BIT       0

// reset values and storable control bits (7, 6 and 1 read as zero)
`define WDIT_CTRL_RESET    16'h8021
`define WDIT_RELOAD_RESET  16'h8000
`define WDIT_COUNT_RESET   16'h8000
`define WDIT_CTRL_MASK     16'hff3d

// length of the system reset pulse in core_clk cycles
`define WDIT_RST_CYCLES    8'h80

`endif

// *** shared/wdit_pkg.sv ***
/*
 * types shared by the watchdog interval timer modules.
 * assumes: the params header sits beside it.
 */
package wdit_pkg;
    // bus answer phase: wait holds waitrequest high
    typedef enum logic {
        WDIT_BUS_DONE = 1'b0,
        WDIT_BUS_WAIT = 1'b1
    } wdit_bus_state_t;

    // reset stretcher phase
    typedef enum logic {
        WDIT_RST_IDLE = 1'b0,
        WDIT_RST_HOLD = 1'b1
    } wdit_rst_state_t;

    // avalon response codes
    typedef enum logic [1:0] {
        WDIT_RESP_OKAY  = 2'h0,
        WDIT_RESP_SLVERR = 2'h2
    } wdit_resp_t;

    // second division factor from the clock select code
    function automatic logic [7:0] wdit_div_factor(input logic [1:0] sel);
        wdit_div_factor = 8'h10 << sel;
    endfunction
endpackage

// *** shared/wdit_tick_if.sv ***
/*
 * carrier between the register core, prescaler and reset stretcher.
 * assumes: all three share core_clk.
 */
`timescale 1ns/1ps
interface wdit_tick_if;
    logic       run;      // timer enable
    logic [7:0] presc;    // prescaler setting
    logic [1:0] div_sel;  // division select code
    logic       tick;     // one-cycle count tick
    logic       fire;     // one-cycle reset request
    logic       sys_rst;  // stretched system reset

    modport core (output run, presc, div_sel, fire, input tick, sys_rst);
    modport pre  (input run, presc, div_sel, output tick);
    modport strch (input fire, output sys_rst);
endinterface

// *** src/wdit_prescaler.sv ***
/*
 * prescaler and second divider producing the count tick.
 * assumes: settings come from the register core on the same clock.
 */
`timescale 1ns/1ps
module wdit_prescaler
    import wdit_pkg::*;
(
    // clock and reset
    input  wire logic core_clk,
    input  wire logic reset,
    // link to the register core
    wdit_tick_if.pre  tk
);
    typedef struct packed {
        logic [7:0] pre_cnt;  // first stage count
        logic [6:0] div_cnt;  // second stage count
        logic       tick;     // registered tick pulse
    } wdit_pre_state_t;

    wdit_pre_state_t state_ff;
    wdit_pre_state_t nxt_state;
    logic [6:0]      div_last;

    // last value of the second stage for the chosen factor
    assign div_last = 7'(wdit_div_factor(tk.div_sel) - 8'h01);
    assign tk.tick  = state_ff.tick;

    // two cascaded counters; held while disabled
    always_comb begin
        nxt_state      = state_ff;
        nxt_state.tick = 1'b0;
        if (tk.run) begin
            // >= so a lowered setting wraps at once instead of running to 255
            if (state_ff.pre_cnt >= tk.presc) begin
                nxt_state.pre_cnt = 8'h00;
                if (state_ff.div_cnt >= div_last) begin
                    nxt_state.div_cnt = 7'h00;
                    nxt_state.tick    = 1'b1;
                end else begin
                    nxt_state.div_cnt = state_ff.div_cnt + 7'h01;
                end
            end else begin
                nxt_state.pre_cnt = state_ff.pre_cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end
endmodule

// *** src/wdit_reset_stretch.sv ***
/*
 * stretches a time-out request into a fixed-length system reset.
 * assumes: the request is a one-cycle pulse.
 */
`timescale 1ns/1ps
`include "wdit_params.svh"
module wdit_reset_stretch
    import wdit_pkg::*;
(
    // clock and reset
    input  wire logic  core_clk,
    input  wire logic  reset,
    // link to the register core
    wdit_tick_if.strch tk
);
    typedef struct packed {
        wdit_rst_state_t st;   // idle or holding reset
        logic [7:0]      cnt;  // cycles left minus one
    } wdit_strch_state_t;

    wdit_strch_state_t state_ff;
    wdit_strch_state_t nxt_state;

    assign tk.sys_rst = (state_ff.st == WDIT_RST_HOLD);

    // a request while holding is ignored: the pulse is never cut or grown
    always_comb begin
        nxt_state = state_ff;
        case (state_ff.st)
            WDIT_RST_IDLE: begin
                if (tk.fire) begin
                    nxt_state.st  = WDIT_RST_HOLD;
                    nxt_state.cnt = `WDIT_RST_CYCLES - 8'h01;
                end
            end
            WDIT_RST_HOLD: begin
                if (state_ff.cnt == 8'h00) begin
                    nxt_state.st = WDIT_RST_IDLE;
                end else begin
                    nxt_state.cnt = state_ff.cnt - 8'h01;
                end
            end
            default: begin
                nxt_state.st = WDIT_RST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_ff <= '{st: WDIT_RST_IDLE, cnt: 8'h00};
        end else begin
            state_ff <= nxt_state;
        end
    end
endmodule

// *** src/wdit_top.sv ***
/*
 * watchdog interval timer: avalon register slave, 16-bit down counter,
 * interrupt pulse and stretched system reset.
 * assumes: one clock core_clk at 25 MHz, synchronous reset, inputs
 * already synchronous to core_clk, master obeys avalon waitrequest.
 */
// Local design decision: the Avalon-MM interface to the registers.
// Summary of operation
// - time-out with reset enabled: 128-cycle reset
// - bus clock only, prescaled then divided
// - control 15:8 prescale, divide by setting+1
// - control 4:3 selects 16/32/64/128 divider
// - tick = (setting+1) times factor cycles
// - control bit 5 enables counting
// - control bit 2 gates time-out interrupt
// - control bit 0 gates time-out reset
// - control resets to 0x8021
// - enabling does not load the reload value
// - reload after each time-out, first from 0x8000
// - reload register, 16 bits, resets 0x8000
// - count register readable, writable, resets 0x8000
// - 16-bit down count, time-out at zero
// - debug acknowledge blocks the reset output
`timescale 1ns/1ps
`include "wdit_params.svh"
module wdit_top
    import wdit_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset,
    // avalon-mm slave
    input  wire logic [31:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic [1:0]       avs_response,
    output logic             avs_waitrequest,
    // processor core debug state
    input  wire logic        core_debug_acknowledge,
    // events
    output logic             timeout_irq,
    output logic             system_reset
);

    // all state of the register core
    typedef struct packed {
        wdit_bus_state_t bus;     // answer phase of the slave
        logic [15:0]     ctrl;    // watchdog_control
        logic [15:0]     reload;  // watchdog_reload_value
        logic [15:0]     count;   // watchdog_current_count
        logic [31:0]     rdata;   // registered read data
        logic [1:0]      resp;    // registered response code
        logic            irq;     // interrupt pulse
        logic            fire;    // reset request to the stretcher
    } wdit_core_state_t;

    wdit_core_state_t state_ff;   // registered state
    wdit_core_state_t nxt_state;  // next state

    // decoded access of the current cycle
    logic             req;        // read or write pending
    logic             wr_take;    // write completes at this edge
    logic             hit_ctrl;   // control selected
    logic             hit_reload; // reload selected
    logic             hit_count;  // count selected
    logic             hit_any;    // any mapped register
    logic             timeout;    // count expires this cycle
    logic             rst_allow;  // reset output may fire

    // carrier to the prescaler and stretcher
    wdit_tick_if tk ();

    // merge a write into a 16-bit register by byte lanes
    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [31:0] wd,
        input logic [3:0]  be
    );
        logic [15:0] res;
        res = old;
        if (be[0]) begin
            res[7:0] = wd[7:0];
        end
        if (be[1]) begin
            res[15:8] = wd[15:8];
        end
        merge16 = res;
    endfunction

    // settings for the prescaler come straight from the control register
    assign tk.run     = state_ff.ctrl[`WDIT_EN_BIT];
    assign tk.presc   = state_ff.ctrl[`WDIT_PRESC_HI:`WDIT_PRESC_LO];
    assign tk.div_sel = state_ff.ctrl[`WDIT_DIV_HI:`WDIT_DIV_LO];
    assign tk.fire    = state_ff.fire;

    // outputs, each straight from a flip-flop
    assign avs_readdata    = state_ff.rdata;
    assign avs_response    = state_ff.resp;
    assign avs_waitrequest = logic'(state_ff.bus);
    assign timeout_irq     = state_ff.irq;
    assign system_reset    = tk.sys_rst;

    // address decode; only whole-word addresses hit
    assign hit_ctrl   = (avs_address == `WDIT_CTRL_ADDR);
    assign hit_reload = (avs_address == `WDIT_RELOAD_ADDR);
    assign hit_count  = (avs_address == `WDIT_COUNT_ADDR);
    assign hit_any    = hit_ctrl | hit_reload | hit_count;

    // a request is pending whenever the master drives read or write
    assign req = avs_read | avs_write;

    // the write lands only at the edge where waitrequest is seen low
    assign wr_take = avs_write & (state_ff.bus == WDIT_BUS_DONE);

    // time-out: a tick arrives while enabled and the count sits at zero;
    // the enable term stops a tick already in flight after a disable
    assign timeout = tk.tick & state_ff.ctrl[`WDIT_EN_BIT]
                   & (state_ff.count == 16'h0000);

    // debug acknowledge masks the reset, never the interrupt
    assign rst_allow = state_ff.ctrl[`WDIT_RST_BIT]
                     & ~core_debug_acknowledge;

    // register core next-state logic
    always_comb begin
        nxt_state      = state_ff;
        nxt_state.irq  = 1'b0;
        nxt_state.fire = 1'b0;

        // slave handshake: one wait cycle, then one answer cycle
        case (state_ff.bus)
            WDIT_BUS_WAIT: begin
                if (req) begin
                    // the answer is prepared now and shown next cycle
                    nxt_state.bus   = WDIT_BUS_DONE;
                    nxt_state.rdata = 32'h0000_0000;
                    nxt_state.resp  = WDIT_RESP_OKAY;
                    if (!hit_any) begin
                        // unmapped: zero data and an error response
                        nxt_state.resp = WDIT_RESP_SLVERR;
                    end else if (avs_read) begin
                        if (hit_ctrl) begin
                            // reserved bits are never stored, so read zero
                            nxt_state.rdata[15:0] = state_ff.ctrl;
                        end else if (hit_reload) begin
                            nxt_state.rdata[15:0] = state_ff.reload;
                        end else begin
                            // live count; a snapshot one cycle old
                            nxt_state.rdata[15:0] = state_ff.count;
                        end
                    end
                end
            end
            WDIT_BUS_DONE: begin
                // transfer completes at this edge; back to waiting
                nxt_state.bus = WDIT_BUS_WAIT;
            end
            default: begin
                nxt_state.bus = WDIT_BUS_WAIT;
            end
        endcase

        // down counter; held while the enable bit is clear
        if (timeout) begin
            // reload only after a time-out, never on enabling
            nxt_state.count = state_ff.reload;
            // interrupt only when its enable bit is set
            nxt_state.irq  = state_ff.ctrl[`WDIT_IRQ_BIT];
            nxt_state.fire = rst_allow;
        end else if (tk.tick & state_ff.ctrl[`WDIT_EN_BIT]) begin
            nxt_state.count = state_ff.count - 16'h0001;
        end

        // software writes; a count write beats a tick in the same cycle
        if (wr_take & hit_ctrl) begin
            // reserved bits 7, 6 and 1 are dropped on write
            nxt_state.ctrl = merge16(state_ff.ctrl, avs_writedata, avs_byteenable)
                           & `WDIT_CTRL_MASK;
        end
        if (wr_take & hit_reload) begin
            nxt_state.reload = merge16(state_ff.reload, avs_writedata,
                                       avs_byteenable);
        end
        if (wr_take & hit_count) begin
            nxt_state.count = merge16(state_ff.count, avs_writedata,
                                      avs_byteenable);
        end
    end

    // register core state; control reset value enables the watchdog at once
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_ff.bus    <= WDIT_BUS_WAIT;
            state_ff.ctrl   <= `WDIT_CTRL_RESET;
            state_ff.reload <= `WDIT_RELOAD_RESET;
            state_ff.count  <= `WDIT_COUNT_RESET;
            state_ff.rdata  <= 32'h0000_0000;
            state_ff.resp   <= WDIT_RESP_OKAY;
            state_ff.irq    <= 1'b0;
            state_ff.fire   <= 1'b0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // tick generator: prescaler then second divider
    wdit_prescaler u_pre (
        .core_clk (core_clk),
        .reset    (reset),
        .tk       (tk.pre)
    );

    // stretcher: holds the system reset for the fixed length
    wdit_reset_stretch u_strch (
        .core_clk (core_clk),
        .reset    (reset),
        .tk       (tk.strch)
    );

endmodule

// *** tb/tb.sv ***
/*
 * self-checking bench for the watchdog interval timer.
 * assumes: wdit_top with its checker bound; bench acts as avalon master.
 */
`timescale 1ns/1ps
`include "wdit_params.svh"
module tb;
    logic        core_clk;    // 25 MHz clock
    logic        reset;       // synchronous reset
    logic [31:0] avs_address; // bus request fields
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic [1:0]  avs_response;
    logic        avs_waitrequest;
    logic        core_debug_acknowledge;
    logic        timeout_irq;
    logic        system_reset;
    logic [15:0] rd;          // last read data
    logic [1:0]  rs;          // last response
    int          err_count = 0;
    int          cmp_count = 0;
    int          cyc = 0;     // cycle ceiling counter
    int          n;

    wdit_top uut (.core_clk(core_clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_response(avs_response), .avs_waitrequest(avs_waitrequest),
        .core_debug_acknowledge(core_debug_acknowledge), .timeout_irq(timeout_irq),
        .system_reset(system_reset));

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // hang guard: whole run needs well under 25000 cycles
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_count++;
            $display("[FAIL] %0t run timed out", $time);
            test_done();
        end
    end

    task test_done;
        $display("mismatches %0d comparisons %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // one avalon transfer; held until waitrequest is seen low at an edge
    task bus(input logic wr, input logic [31:0] a, input logic [15:0] d, input logic [3:0] be);
        int k;
        k = 0;
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= {16'h0, d};
        avs_byteenable <= be;
        // wait for the answer however long it takes; only the hang guard ends it
        do begin
            @(posedge core_clk);
            k++;
        end while (avs_waitrequest !== 1'b0);
        // slave answers one cycle after taking the request, seen at the second edge
        chk16(16'(k), 16'h0002, "bus answer latency");
        rd = avs_readdata[15:0];
        rs = avs_response;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // idle edge so the next request is never driven in this time step
        @(posedge core_clk);
    endtask

    task rd_reg(input logic [31:0] a, input logic [15:0] exp);
        bus(1'b0, a, 16'h0, 4'h0);
        chk16(rd, exp, "read data");
        chk16({14'h0, rs}, 16'h0, "read response");
    endtask

    // wait for one irq pulse; n gives the edges waited
    task wait_irq;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (timeout_irq !== 1'b1 && n < 9000);
        chk16({15'h0, timeout_irq}, 16'h1, "irq seen");
    endtask

    // neither event may show for k cycles
    task quiet(input int k);
        logic bad;
        bad = 1'b0;
        repeat (k) begin
            @(posedge core_clk);
            if (timeout_irq !== 1'b0 || system_reset !== 1'b0) bad = 1'b1;
        end
        chk16({15'h0, bad}, 16'h0, "unexpected event");
    endtask

    task t_defaults;
        rd_reg(`WDIT_CTRL_ADDR, 16'h8021);
        rd_reg(`WDIT_RELOAD_ADDR, 16'h8000);
        rd_reg(`WDIT_COUNT_ADDR, 16'h8000);
    endtask

    // reserved bits, byte lanes and an unmapped place
    task t_regs;
        // software keeps reserved bits 7, 6 and 1 at zero
        bus(1'b1, `WDIT_CTRL_ADDR, 16'hff3d, 4'h3);
        rd_reg(`WDIT_CTRL_ADDR, 16'hff3d);
        bus(1'b1, `WDIT_CTRL_ADDR, 16'h0000, 4'h3);
        bus(1'b1, `WDIT_RELOAD_ADDR, 16'h1234, 4'h1);
        rd_reg(`WDIT_RELOAD_ADDR, 16'h8034);
        bus(1'b1, `WDIT_COUNT_ADDR, 16'habcd, 4'h2);
        rd_reg(`WDIT_COUNT_ADDR, 16'hab00);
        bus(1'b1, 32'h5200_000c, 16'h0021, 4'h3);
        chk16({14'h0, rs}, 16'h2, "unmapped write response");
        bus(1'b0, 32'h5200_000c, 16'h0, 4'h0);
        chk16({14'h0, rs}, 16'h2, "unmapped read response");
        rd_reg(`WDIT_CTRL_ADDR, 16'h0000);
    endtask

    // disabled timer holds its count and stays silent
    task t_disabled;
        bus(1'b1, `WDIT_COUNT_ADDR, 16'h0000, 4'h3);
        bus(1'b1, `WDIT_CTRL_ADDR, 16'h0005, 4'h3);
        quiet(300);
        rd_reg(`WDIT_COUNT_ADDR, 16'h0000);
    endtask

    // enabling counts on from the count, not from the reload value
    task t_noload;
        bus(1'b1, `WDIT_RELOAD_ADDR, 16'h0003, 4'h3);
        bus(1'b1, `WDIT_COUNT_ADDR, 16'h0010, 4'h3);
        bus(1'b1, `WDIT_CTRL_ADDR, 16'h0024, 4'h3);
        repeat (40) @(posedge core_clk);
        bus(1'b0, `WDIT_COUNT_ADDR, 16'h0, 4'h0);
        chk16({15'h0, rd >= 16'h000d && rd <= 16'h000f}, 16'h1, "count after enable");
    endtask

    // period between two pulses is (reload+1)*(p+1)*factor cycles
    task t_period(input logic [7:0] p, input logic [1:0] dv, input logic [15:0] rl);
        bus(1'b1, `WDIT_CTRL_ADDR, 16'h0000, 4'h3);
        bus(1'b1, `WDIT_RELOAD_ADDR, rl, 4'h3);
        bus(1'b1, `WDIT_COUNT_ADDR, 16'h0000, 4'h3);
        // interval use: interrupt on, reset output off
        bus(1'b1, `WDIT_CTRL_ADDR, {p, 3'b001, dv, 3'b100}, 4'h3);
        wait_irq();
        wait_irq();
        chk16(16'(n), 16'((rl + 1) * (p + 1) * (16 << dv)), "period");
    endtask

    // reset pulse, no retrigger, debug masking and both enables off
    task t_reset_out;
        bus(1'b1, `WDIT_CTRL_ADDR, 16'h0000, 4'h3);
        bus(1'b1, `WDIT_RELOAD_ADDR, 16'h0003, 4'h3);
        bus(1'b1, `WDIT_COUNT_ADDR, 16'h0000, 4'h3);
        bus(1'b1, `WDIT_CTRL_ADDR, 16'h0025, 4'h3);
        wait_irq();
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (system_reset === 1'b1 && n < 300);
        chk16(16'(n - 1), 16'h0080, "reset pulse cycles");
        core_debug_acknowledge <= 1'b1;
        wait_irq();
        quiet(4);
        core_debug_acknowledge <= 1'b0;
        bus(1'b1, `WDIT_CTRL_ADDR, 16'h0020, 4'h3);
        quiet(200);
    endtask

    initial begin
        reset = 1'b1;
        avs_address = 32'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        core_debug_acknowledge = 1'b0;
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        t_defaults();
        t_regs();
        t_disabled();
        t_noload();
        for (int d = 0; d < 4; d++) begin
            t_period(8'h00, 2'(d), 16'h0001);
        end
        t_period(8'hff, 2'h0, 16'h0000);
        t_period(8'h02, 2'h1, 16'h0002);
        t_reset_out();
        test_done();
    end
endmodule

// *** tb/wdit_checker.sv ***
/*
 * port assertions for the watchdog interval timer.
 * assumes: bound onto wdit_top; one clock core_clk, synchronous reset.
 */
`timescale 1ns/1ps
`include "wdit_params.svh"
module wdit_checker (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        reset,
    // avalon slave
    input wire logic [31:0] avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic [1:0]  avs_response,
    input wire logic        avs_waitrequest,
    // debug and events
    input wire logic        core_debug_acknowledge,
    input wire logic        timeout_irq,
    input wire logic        system_reset
);
    logic [7:0] hi_cnt_ff;  // high cycles of the current reset pulse
    logic [7:0] nxt_hi_cnt; // next pulse length
    logic       take;       // request taken at this edge
    logic       mapped;     // address hits one of the three registers

    // pulse length counter; a repetition of 128 would be far too costly
    always_comb begin
        nxt_hi_cnt = system_reset ? hi_cnt_ff + 8'h01 : 8'h00;
    end

    // register the counter
    always_ff @(posedge core_clk) begin
        if (reset) begin
            hi_cnt_ff <= 8'h00;
        end else begin
            hi_cnt_ff <= nxt_hi_cnt;
        end
    end

    assign take   = (avs_read || avs_write) && avs_waitrequest;
    assign mapped = avs_address == `WDIT_CTRL_ADDR || avs_address == `WDIT_RELOAD_ADDR
                    || avs_address == `WDIT_COUNT_ADDR;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    // answer phase: one low cycle, then high again
    sequence answer_s;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    rst_len_a: assert property (
        $fell(system_reset) |-> hi_cnt_ff == 8'h80) else $error("reset pulse length wrong");
    rst_bound_a: assert property (
        system_reset |-> hi_cnt_ff < 8'h80) else $error("reset pulse too long");
    irq_spacing_a: assert property (
        timeout_irq |=> !timeout_irq [*8]) else $error("irq not a lone pulse");
    dbg_mask_a: assert property (
        $rose(system_reset) |-> !$past(core_debug_acknowledge, 2)) else $error("reset in debug");
    bus_answer_a: assert property (
        take |=> answer_s) else $error("bus answer timing wrong");
    bus_idle_a: assert property (
        !(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest) else $error("stray answer");
    unmapped_err_a: assert property (
        take && !mapped |=> avs_response == 2'h2 && avs_readdata == 32'h0)
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (
        take && mapped |=> avs_response == 2'h0 && avs_readdata[31:16] == 16'h0)
        else $error("mapped access answer wrong");
endmodule

bind wdit_top wdit_checker u_chk (.core_clk, .reset, .avs_address, .avs_read, .avs_write,
    .avs_readdata, .avs_response, .avs_waitrequest, .core_debug_acknowledge, .timeout_irq,
    .system_reset);
